// ===== hw/fcmd_regs.svh
// Function
// - Host writes start operations; only reset aborts, suspend pauses
// - FF selects array read; 50 clears status
// - 90 selects identifier, 98 selects query reads
// - 70 selects status; next read returns status
// - Word program: 40 then address and data
// - Buffered program: E8, count-1, words, D0
// - Factory bulk program: 80, D0, then words
// - Block erase: 20 then D0 in block
// - B0 suspends running operation; D0 resumes it
// - 60 then 01 lock, D0 unlock, 2F lockdown
// - C0 then register address and data programs
// - 60 then 03 loads configuration from address
// - Blank check: BC then D0 in block
// - Extended function: EB, subcode, N-1, words, D0
// - Asynchronous page reads after reset; burst needs configuration
// - Four read states; array after reset
// - Wait held deasserted, polarity from configuration bit 10
// - Clock ignored by async reads; data after access
// - Page reads only from array with bit 15
// - Sixteen words sensed; low four bits select
// - Bad confirm sets status bits 4 and 5
// - Suspend sets ready plus suspended flag
`ifndef FCMD_REGS_SVH
`define FCMD_REGS_SVH
`define FCMD_AW 27
`define FCMD_CMD_RD_ARRAY 8'hFF
`define FCMD_CMD_RD_ID 8'h90
`define FCMD_CMD_RD_QUERY 8'h98
`define FCMD_CMD_RD_STATUS 8'h70
`define FCMD_CMD_CLR_STATUS 8'h50
`define FCMD_CMD_WORD_PROG 8'h40
`define FCMD_CMD_BUF_PROG 8'hE8
`define FCMD_CMD_BULK_PROG 8'h80
`define FCMD_CMD_ERASE 8'h20
`define FCMD_CMD_SUSPEND 8'hB0
`define FCMD_CMD_CONFIRM 8'hD0
`define FCMD_CMD_PROT_SETUP 8'h60
`define FCMD_CMD_LOCK 8'h01
`define FCMD_CMD_LOCKDOWN 8'h2F
`define FCMD_CMD_RCFG 8'h03
`define FCMD_CMD_OTP_PROG 8'hC0
`define FCMD_CMD_BLANK 8'hBC
`define FCMD_CMD_EXT_FUNC 8'hEB
`define FCMD_BUF_MAX_M1 16'h01FF
`define FCMD_SR_READY 7
`define FCMD_SR_ERASE_SUSP 6
`define FCMD_SR_ERASE_ERR 5
`define FCMD_SR_PROG_ERR 4
`define FCMD_SR_PROG_SUSP 2
`define FCMD_RCFG_PAGE 15
`define FCMD_RCFG_WAIT_POL 10
`define FCMD_RCFG_RST 16'h8000
`define FCMD_PAGE_WORDS 16
`endif

// ===== hw/fcmd_pkg.sv
`default_nettype none
`include "fcmd_regs.svh"
package fcmd_pkg;
  typedef enum logic [1:0] {
    FCMD_RS_ARRAY = 2'h0,
    FCMD_RS_ID = 2'h1,
    FCMD_RS_STATUS = 2'h2,
    FCMD_RS_QUERY = 2'h3
  } fcmd_rstate_type;
  typedef enum logic [2:0] {
    FCMD_S_IDLE = 3'h0,
    FCMD_S_SETUP = 3'h1,
    FCMD_S_COUNT = 3'h3,
    FCMD_S_DATA = 3'h2,
    FCMD_S_CONFIRM = 3'h6,
    FCMD_S_SUBOP = 3'h7,
    FCMD_S_BULK = 3'h5
  } fcmd_state_type;
  typedef enum logic [3:0] {
    FCMD_OP_NONE, FCMD_OP_WORD_PROG, FCMD_OP_BUF_WORD, FCMD_OP_BUF_PROG,
    FCMD_OP_BULK_START, FCMD_OP_BULK_WORD, FCMD_OP_ERASE, FCMD_OP_LOCK,
    FCMD_OP_UNLOCK, FCMD_OP_LOCKDOWN, FCMD_OP_OTP_PROG, FCMD_OP_BLANK,
    FCMD_OP_EXT_WORD, FCMD_OP_EXT_GO, FCMD_OP_SUSPEND, FCMD_OP_RESUME
  } fcmd_op_kind_type;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [`FCMD_AW-1:0] addr;
    logic [15:0] data;
  } fcmd_bus_type;
  typedef struct packed {
    logic valid;
    fcmd_op_kind_type kind;
    logic [`FCMD_AW-1:0] addr;
    logic [15:0] data;
  } fcmd_op_type;
endpackage : fcmd_pkg
`default_nettype wire

// ===== hw/fcmd_page.sv
`default_nettype none
`include "fcmd_regs.svh"
module fcmd_page import fcmd_pkg::*; #(
  parameter int WORDS = `FCMD_PAGE_WORDS
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic rd_i,
  input wire logic page_en_i,
  input wire logic inval_i,
  input wire logic [`FCMD_AW-1:0] addr_i,
  input wire logic [WORDS*16-1:0] page_i,
  output logic [15:0] word_o
);
  localparam int SEL_W = $clog2(WORDS);
  logic [15:0] buf_q [WORDS];
  logic [`FCMD_AW-SEL_W-1:0] tag_q;
  logic hit_valid_q;
  wire [SEL_W-1:0] sel = addr_i[SEL_W-1:0];
  wire [`FCMD_AW-SEL_W-1:0] tag = addr_i[`FCMD_AW-1:SEL_W];
  wire hit = page_en_i & hit_valid_q & (tag_q == tag);
  // Low address bits pick the word out of the sensed page
  assign word_o = hit ? buf_q[sel] : page_i[sel*16 +: 16];
  // Whole page is sensed at once on a miss
  always_ff @(posedge clk_i) begin
    if (srst_i | inval_i) begin
      hit_valid_q <= 1'b0;
    end else if (rd_i & ~hit) begin
      hit_valid_q <= page_en_i;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rd_i & ~hit) begin
      tag_q <= tag;
      for (int i = 0; i < WORDS; i++) begin
        buf_q[i] <= page_i[i*16 +: 16];
      end
    end
  end
endmodule : fcmd_page
`default_nettype wire

// ===== hw/fcmd_core.sv
// Added by the designer: the plain strobed port and the register addresses.
`default_nettype none
`include "fcmd_regs.svh"
module fcmd_core import fcmd_pkg::*; #(
  parameter int BLK_LSB = 16
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire fcmd_bus_type bus_i,
  input wire logic address_valid_strobe_n_i,
  input wire logic [15:0] info_word_i,
  input wire logic [`FCMD_PAGE_WORDS*16-1:0] array_page_i,
  input wire logic op_done_i,
  output logic [15:0] rdata_o,
  output logic rvalid_o,
  output logic wait_o,
  output fcmd_rstate_type rstate_o,
  output logic [7:0] status_o,
  output logic [15:0] read_configuration_o,
  output logic sync_burst_o,
  output fcmd_op_type op_o
);
  fcmd_state_type st_q, st_d;
  fcmd_rstate_type rs_q, rs_d;
  logic [7:0] setup_q, setup_d;
  logic [7:0] subop_q, subop_d;
  logic [8:0] cnt_q, cnt_d;
  logic [8:0] total_q, total_d;
  logic ext_q, ext_d;
  logic [`FCMD_AW-1:0] base_q, base_d;
  logic [`FCMD_AW-1:0] lat_q;
  logic [15:0] rcfg_q, rcfg_d;
  fcmd_op_type op_d, op_q;
  logic busy_q;
  logic run_erase_q;
  logic prog_susp_q;
  logic erase_susp_q;
  logic prog_err_q;
  logic erase_err_q;
  logic seq_err;
  logic start;
  logic start_erase;
  logic clr_sr;
  logic do_susp;
  logic do_resume;
  logic [15:0] rdata_q;
  logic rvalid_q;
  logic wait_q;
  logic burst_q;

  function automatic fcmd_op_type mk_op(input fcmd_op_kind_type kind,
                                        input logic [`FCMD_AW-1:0] addr,
                                        input logic [15:0] data);
    fcmd_op_type o;
    o.valid = 1'b1;
    o.kind = kind;
    o.addr = addr;
    o.data = data;
    return o;
  endfunction : mk_op

  wire [7:0] cmd = bus_i.data[7:0];
  wire wr = bus_i.wr;
  wire susp_any = prog_susp_q | erase_susp_q;
  // Algorithm still owns the array unless suspended
  wire run = busy_q & ~susp_any;
  wire cmd_is_read = (cmd == `FCMD_CMD_RD_ARRAY) | (cmd == `FCMD_CMD_RD_ID) |
                     (cmd == `FCMD_CMD_RD_QUERY) | (cmd == `FCMD_CMD_RD_STATUS);
  wire cmd_ok_busy = cmd_is_read | (cmd == `FCMD_CMD_SUSPEND) |
                     (cmd == `FCMD_CMD_CLR_STATUS);
  wire is_confirm = cmd == `FCMD_CMD_CONFIRM;
  wire same_block = bus_i.addr[`FCMD_AW-1:BLK_LSB] == base_q[`FCMD_AW-1:BLK_LSB];
  wire count_ok = bus_i.data <= `FCMD_BUF_MAX_M1;
  wire ready = ~busy_q | susp_any;
  wire [7:0] status = {ready, erase_susp_q, erase_err_q, prog_err_q,
                       1'b0, prog_susp_q, 2'b00};
  // Strobe high keeps the latched address; low lets it flow
  wire [`FCMD_AW-1:0] rd_addr = address_valid_strobe_n_i ? lat_q : bus_i.addr;
  wire array_rd = bus_i.rd & (rs_q == FCMD_RS_ARRAY);
  wire page_en = rcfg_q[`FCMD_RCFG_PAGE];
  wire [15:0] page_word;
  wire [15:0] rd_word = (rs_q == FCMD_RS_ARRAY) ? page_word :
                        (rs_q == FCMD_RS_STATUS) ? {8'h00, status} :
                        info_word_i;

  // Page buffer only serves array reads
  fcmd_page #(
    .WORDS(`FCMD_PAGE_WORDS)
  ) u_page (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .rd_i(array_rd),
    .page_en_i(page_en),
    .inval_i(wr),
    .addr_i(rd_addr),
    .page_i(array_page_i),
    .word_o(page_word)
  );

  always_comb begin
    st_d = st_q;
    rs_d = rs_q;
    setup_d = setup_q;
    subop_d = subop_q;
    cnt_d = cnt_q;
    total_d = total_q;
    ext_d = ext_q;
    base_d = base_q;
    rcfg_d = rcfg_q;
    op_d = '0;
    seq_err = 1'b0;
    start = 1'b0;
    start_erase = 1'b0;
    clr_sr = 1'b0;
    do_susp = 1'b0;
    do_resume = 1'b0;
    if (wr) begin
      unique case (st_q)
        FCMD_S_IDLE: begin
          // Running algorithm accepts only reads, clear status and suspend
          if (~run | cmd_ok_busy) begin
            unique case (cmd)
              `FCMD_CMD_RD_ARRAY: rs_d = FCMD_RS_ARRAY;
              `FCMD_CMD_RD_ID: rs_d = FCMD_RS_ID;
              `FCMD_CMD_RD_QUERY: rs_d = FCMD_RS_QUERY;
              `FCMD_CMD_RD_STATUS: rs_d = FCMD_RS_STATUS;
              `FCMD_CMD_CLR_STATUS: clr_sr = 1'b1;
              `FCMD_CMD_SUSPEND: begin
                if (run) begin
                  do_susp = 1'b1;
                  rs_d = FCMD_RS_STATUS;
                  op_d = mk_op(FCMD_OP_SUSPEND, bus_i.addr, bus_i.data);
                end
              end
              `FCMD_CMD_CONFIRM: begin
                if (susp_any) begin
                  do_resume = 1'b1;
                  op_d = mk_op(FCMD_OP_RESUME, bus_i.addr, bus_i.data);
                end
              end
              `FCMD_CMD_WORD_PROG, `FCMD_CMD_ERASE, `FCMD_CMD_PROT_SETUP,
              `FCMD_CMD_OTP_PROG, `FCMD_CMD_BLANK, `FCMD_CMD_BULK_PROG: begin
                // Bulk block reference taken from the first cycle; op target from the second
                st_d = FCMD_S_SETUP;
                setup_d = cmd;
                base_d = bus_i.addr;
                rs_d = FCMD_RS_STATUS;
              end
              `FCMD_CMD_BUF_PROG: begin
                st_d = FCMD_S_COUNT;
                ext_d = 1'b0;
                base_d = bus_i.addr;
                rs_d = FCMD_RS_STATUS;
              end
              `FCMD_CMD_EXT_FUNC: begin
                st_d = FCMD_S_SUBOP;
                ext_d = 1'b1;
                base_d = bus_i.addr;
                rs_d = FCMD_RS_STATUS;
              end
              default: ;
            endcase
          end
        end
        FCMD_S_SETUP: begin
          st_d = FCMD_S_IDLE;
          unique case (setup_q)
            `FCMD_CMD_WORD_PROG: begin
              start = 1'b1;
              op_d = mk_op(FCMD_OP_WORD_PROG, bus_i.addr, bus_i.data);
            end
            `FCMD_CMD_OTP_PROG: begin
              start = 1'b1;
              op_d = mk_op(FCMD_OP_OTP_PROG, bus_i.addr, bus_i.data);
            end
            `FCMD_CMD_ERASE: begin
              if (is_confirm) begin
                start_erase = 1'b1;
                op_d = mk_op(FCMD_OP_ERASE, bus_i.addr, bus_i.data);
              end else begin
                seq_err = 1'b1;
              end
            end
            `FCMD_CMD_BLANK: begin
              if (is_confirm) begin
                start = 1'b1;
                op_d = mk_op(FCMD_OP_BLANK, bus_i.addr, bus_i.data);
              end else begin
                seq_err = 1'b1;
              end
            end
            `FCMD_CMD_BULK_PROG: begin
              if (is_confirm) begin
                start = 1'b1;
                st_d = FCMD_S_BULK;
                op_d = mk_op(FCMD_OP_BULK_START, bus_i.addr, bus_i.data);
              end else begin
                seq_err = 1'b1;
              end
            end
            `FCMD_CMD_PROT_SETUP: begin
              unique case (cmd)
                `FCMD_CMD_LOCK: op_d = mk_op(FCMD_OP_LOCK, bus_i.addr, bus_i.data);
                `FCMD_CMD_CONFIRM: op_d = mk_op(FCMD_OP_UNLOCK, bus_i.addr, bus_i.data);
                `FCMD_CMD_LOCKDOWN: op_d = mk_op(FCMD_OP_LOCKDOWN, bus_i.addr, bus_i.data);
                `FCMD_CMD_RCFG: begin
                  // New value rides on the address lines
                  rcfg_d = bus_i.addr[16:1];
                  rs_d = FCMD_RS_ARRAY;
                end
                default: seq_err = 1'b1;
              endcase
            end
            default: ;
          endcase
        end
        FCMD_S_SUBOP: begin
          subop_d = cmd;
          st_d = FCMD_S_COUNT;
        end
        FCMD_S_COUNT: begin
          // Counts beyond the buffer size are rejected
          if (count_ok) begin
            cnt_d = bus_i.data[8:0];
            total_d = bus_i.data[8:0];
            st_d = FCMD_S_DATA;
          end else begin
            seq_err = 1'b1;
          end
        end
        FCMD_S_DATA: begin
          op_d = mk_op(ext_q ? FCMD_OP_EXT_WORD : FCMD_OP_BUF_WORD,
                       bus_i.addr, bus_i.data);
          if (cnt_q == 9'h000) begin
            st_d = FCMD_S_CONFIRM;
          end else begin
            cnt_d = cnt_q - 9'h001;
          end
        end
        FCMD_S_CONFIRM: begin
          st_d = FCMD_S_IDLE;
          if (is_confirm) begin
            start = 1'b1;
            op_d = mk_op(ext_q ? FCMD_OP_EXT_GO : FCMD_OP_BUF_PROG, base_q,
                         ext_q ? {8'h00, subop_q} : {7'h00, total_q});
          end else begin
            seq_err = 1'b1;
          end
        end
        FCMD_S_BULK: begin
          // Leaving the block ends the stream of bulk words
          if (same_block) begin
            op_d = mk_op(FCMD_OP_BULK_WORD, bus_i.addr, bus_i.data);
          end else begin
            st_d = FCMD_S_IDLE;
          end
        end
        default: st_d = FCMD_S_IDLE;
      endcase
      if (seq_err) begin
        st_d = FCMD_S_IDLE;
        rs_d = FCMD_RS_STATUS;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_q <= FCMD_S_IDLE;
      rs_q <= FCMD_RS_ARRAY;
      rcfg_q <= `FCMD_RCFG_RST;
      op_q <= '0;
    end else begin
      st_q <= st_d;
      rs_q <= rs_d;
      rcfg_q <= rcfg_d;
      op_q <= op_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      setup_q <= 8'h00;
      subop_q <= 8'h00;
      cnt_q <= 9'h000;
      total_q <= 9'h000;
      ext_q <= 1'b0;
      base_q <= '0;
      lat_q <= '0;
    end else begin
      setup_q <= setup_d;
      subop_q <= subop_d;
      cnt_q <= cnt_d;
      total_q <= total_d;
      ext_q <= ext_d;
      base_q <= base_d;
      if (~address_valid_strobe_n_i) begin
        lat_q <= bus_i.addr;
      end
    end
  end

  // Reset is the only abort; suspend leaves busy set
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      busy_q <= 1'b0;
      run_erase_q <= 1'b0;
    end else begin
      if (start | start_erase) begin
        busy_q <= 1'b1;
        run_erase_q <= start_erase;
      end else if (op_done_i & run) begin
        busy_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      prog_susp_q <= 1'b0;
      erase_susp_q <= 1'b0;
    end else if (do_susp) begin
      prog_susp_q <= ~run_erase_q;
      erase_susp_q <= run_erase_q;
    end else if (do_resume) begin
      prog_susp_q <= 1'b0;
      erase_susp_q <= 1'b0;
    end
  end

  // A sequence error in the clearing cycle keeps its bits
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      prog_err_q <= 1'b0;
      erase_err_q <= 1'b0;
    end else begin
      prog_err_q <= seq_err | (prog_err_q & ~clr_sr);
      erase_err_q <= seq_err | (erase_err_q & ~clr_sr);
    end
  end

  // Data follows the read strobe by one cycle; no clock-timed burst
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rdata_q <= 16'h0000;
      rvalid_q <= 1'b0;
      // Deasserted level for the reset configuration, so no false wait
      wait_q <= 1'b1;
      burst_q <= 1'b0;
    end else begin
      rvalid_q <= bus_i.rd;
      if (bus_i.rd) begin
        rdata_q <= rd_word;
      end
      wait_q <= ~rcfg_q[`FCMD_RCFG_WAIT_POL];
      burst_q <= ~rcfg_q[`FCMD_RCFG_PAGE];
    end
  end

  assign rdata_o = rdata_q;
  assign rvalid_o = rvalid_q;
  assign wait_o = wait_q;
  assign rstate_o = rs_q;
  assign read_configuration_o = rcfg_q;
  assign sync_burst_o = burst_q;
  assign op_o = op_q;
  // Status flops plus combined ready are registered here
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      status_o <= 8'h80;
    end else begin
      status_o <= status;
    end
  end
endmodule : fcmd_core
`default_nettype wire

// ===== testbench/fcmd_monitor.sv
`default_nettype none
`include "fcmd_regs.svh"
module fcmd_monitor import fcmd_pkg::*; #(
  parameter int BLK_LSB = 16
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire fcmd_bus_type bus_i,
  input wire logic address_valid_strobe_n_i,
  input wire logic [15:0] info_word_i,
  input wire logic [`FCMD_PAGE_WORDS*16-1:0] array_page_i,
  input wire logic op_done_i,
  input wire logic [15:0] rdata_o,
  input wire logic rvalid_o,
  input wire logic wait_o,
  input wire fcmd_rstate_type rstate_o,
  input wire logic [7:0] status_o,
  input wire logic [15:0] read_configuration_o,
  input wire logic sync_burst_o,
  input wire fcmd_op_type op_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  wire logic [7:0] cmd = bus_i.data[7:0];
  read_answer_a: assert property (bus_i.rd |=> rvalid_o)
    else $error("read not answered in the next cycle");
  array_word_a: assert property (bus_i.rd && !address_valid_strobe_n_i && rstate_o == FCMD_RS_ARRAY
    |=> rdata_o == $past(array_page_i[{bus_i.addr[3:0], 4'h0} +: 16]))
    else $error("array read returned the wrong page word");
  info_word_a: assert property (bus_i.rd && rstate_o inside {FCMD_RS_ID, FCMD_RS_QUERY}
    |=> rdata_o == $past(info_word_i))
    else $error("identifier or query read returned the wrong word");
  op_from_write_a: assert property (op_o.valid |-> $past(bus_i.wr))
    else $error("operation started without a write");
  op_fields_a: assert property (op_o.valid && op_o.kind inside {FCMD_OP_WORD_PROG, FCMD_OP_ERASE}
    |-> op_o.addr == $past(bus_i.addr) && op_o.data == $past(bus_i.data))
    else $error("operation address or data not from its write");
  wait_level_a: assert property (!$past(srst_i) |-> wait_o == !$past(read_configuration_o[10]))
    else $error("wait output not at its deasserted level");
  cfg_load_a: assert property (status_o[7] && bus_i.wr && cmd == 8'h60 ##1 bus_i.wr && cmd == 8'h03
    |=> read_configuration_o == $past(bus_i.addr[16:1]))
    else $error("configuration not loaded from the address lines");
  bad_confirm_a: assert property (status_o[7] && bus_i.wr && cmd == 8'h20 ##1 bus_i.wr && cmd != 8'hD0
    |-> ##2 status_o[5:4] == 2'b11)
    else $error("bad confirm did not flag a sequence error");
  suspend_flags_a: assert property (op_o.valid && op_o.kind == FCMD_OP_SUSPEND
    |=> status_o[7] && (status_o[6] || status_o[2]))
    else $error("suspend did not show ready with a suspended flag");
  status_sel_a: assert property (status_o[7] && bus_i.wr && cmd == 8'h70 |=> rstate_o == FCMD_RS_STATUS)
    else $error("status read state not selected");
  cover property (op_o.valid && op_o.kind == FCMD_OP_SUSPEND);
  cover property (rvalid_o && rstate_o == FCMD_RS_STATUS);
  cover property (status_o[5:4] == 2'b11);
endmodule : fcmd_monitor
bind fcmd_core fcmd_monitor #(.BLK_LSB(BLK_LSB)) u_mon (.clk_i(clk_i), .srst_i(srst_i), .bus_i(bus_i),
  .address_valid_strobe_n_i(address_valid_strobe_n_i), .info_word_i(info_word_i), .array_page_i(array_page_i),
  .op_done_i(op_done_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .wait_o(wait_o), .rstate_o(rstate_o),
  .status_o(status_o), .read_configuration_o(read_configuration_o), .sync_burst_o(sync_burst_o), .op_o(op_o));
`default_nettype wire

// ===== testbench/fcmd_far_model.sv
`default_nettype none
`include "fcmd_regs.svh"
module fcmd_far_model import fcmd_pkg::*; (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire fcmd_bus_type bus_i,
  input wire fcmd_rstate_type rstate_i,
  input wire fcmd_op_type op_i,
  input wire logic [7:0] delay_i,
  output logic [15:0] info_word_o,
  output logic [`FCMD_PAGE_WORDS*16-1:0] array_page_o,
  output logic op_done_o
);
  logic [8:0] cnt_q;
  logic run_q;
  wire logic starts = op_i.valid && op_i.kind inside {FCMD_OP_WORD_PROG, FCMD_OP_BUF_PROG, FCMD_OP_ERASE,
    FCMD_OP_LOCK, FCMD_OP_UNLOCK, FCMD_OP_LOCKDOWN, FCMD_OP_OTP_PROG, FCMD_OP_BLANK, FCMD_OP_EXT_GO};
  assign info_word_o = (rstate_i == FCMD_RS_ID) ? ~bus_i.addr[15:0] : bus_i.addr[15:0] ^ 16'h0F0F;
  // Whole page of the addressed word, low nibble picks the word
  always_comb begin
    for (int i = 0; i < `FCMD_PAGE_WORDS; i++) begin
      array_page_o[16*i +: 16] = {bus_i.addr[15:4], 4'(i)} ^ 16'h3C96;
    end
  end
  // Count freezes while suspended so resume finishes the remainder
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      run_q <= 1'h0;
      cnt_q <= 9'h000;
      op_done_o <= 1'h0;
    end else begin
      op_done_o <= run_q && cnt_q == 9'h001;
      if (starts) begin
        run_q <= 1'h1;
        cnt_q <= {1'h0, delay_i} + 9'h001;
      end else if (op_i.valid && op_i.kind == FCMD_OP_SUSPEND) begin
        run_q <= 1'h0;
      end else if (op_i.valid && op_i.kind == FCMD_OP_RESUME) begin
        run_q <= 1'h1;
      end else if (run_q) begin
        cnt_q <= cnt_q - 9'h001;
        run_q <= cnt_q != 9'h001;
      end
    end
  end
endmodule : fcmd_far_model
`default_nettype wire

// ===== testbench/tb_top.sv
`default_nettype none
`include "fcmd_regs.svh"
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin \
  $display("MISMATCH %s expected %h seen %h", n, e, a); fail_count++; end end
module tb_top import fcmd_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [26:0] TA = 27'h012_3450;
  logic clk_i = 1'h0;
  logic srst_i = 1'h1;
  fcmd_bus_type bus = '0;
  logic avs_n = 1'h0;
  logic [7:0] dly = 8'h14;
  logic [15:0] info, rdata, cfg;
  logic [255:0] page;
  logic op_done, rvalid, wt, burst;
  logic [7:0] st;
  fcmd_rstate_type rs;
  fcmd_op_type op, last_op;
  int fail_count = 0;
  int n_tests = 0;
  int op_cnt = 0;
  int base = 0;
  logic [15:0] eq[$];
  logic [15:0] c1 [7] = '{16'h0040, 16'h0020, 16'h0060, 16'h0060, 16'h0060, 16'h00C0, 16'h00BC};
  logic [15:0] c2 [7] = '{16'h1234, 16'h00D0, 16'h0001, 16'h00D0, 16'h002F, 16'h5A5A, 16'h00D0};
  fcmd_op_kind_type kk [7] = '{FCMD_OP_WORD_PROG, FCMD_OP_ERASE, FCMD_OP_LOCK, FCMD_OP_UNLOCK,
    FCMD_OP_LOCKDOWN, FCMD_OP_OTP_PROG, FCMD_OP_BLANK};
  logic [15:0] s1 [5] = '{16'h0020, 16'h00BC, 16'h0080, 16'h0060, 16'h00E8};
  logic [15:0] s2 [5] = '{16'h0077, 16'h0077, 16'h0077, 16'h0077, 16'h0200};
  fcmd_core dut (.clk_i(clk_i), .srst_i(srst_i), .bus_i(bus), .address_valid_strobe_n_i(avs_n),
    .info_word_i(info), .array_page_i(page), .op_done_i(op_done), .rdata_o(rdata), .rvalid_o(rvalid),
    .wait_o(wt), .rstate_o(rs), .status_o(st), .read_configuration_o(cfg), .sync_burst_o(burst), .op_o(op));
  fcmd_far_model u_far (.clk_i(clk_i), .srst_i(srst_i), .bus_i(bus), .rstate_i(rs), .op_i(op),
    .delay_i(dly), .info_word_o(info), .array_page_o(page), .op_done_o(op_done));
  always #2 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (op.valid === 1'h1) begin
      last_op <= op;
      op_cnt <= op_cnt + 1;
    end
    if (rvalid === 1'h1) begin
      if (eq.size() == 0) `CHK("rvalid", 1'h0, rvalid)
      else begin
        `CHK("rdata", eq[0], rdata)
        void'(eq.pop_front());
      end
    end
  end
  function automatic logic [15:0] aw(input logic [26:0] a);
    return a[15:0] ^ 16'h3C96;
  endfunction : aw
  task automatic cyc(input logic w, input logic r, input logic [26:0] a, input logic [15:0] d);
    @(posedge clk_i);
    bus <= '{w, r, a, d};
  endtask : cyc
  task automatic wr(input logic [26:0] a, input logic [15:0] d);
    cyc(1'h1, 1'h0, a, d);
  endtask : wr
  task automatic rd(input logic [26:0] a, input logic [15:0] e);
    cyc(1'h0, 1'h1, a, 16'h0000);
    eq.push_back(e);
  endtask : rd
  task automatic gap(input int n);
    repeat (n) cyc(1'h0, 1'h0, '0, 16'h0000);
    #1;
  endtask : gap
  task automatic chk_op(input fcmd_op_kind_type k, input logic [26:0] a, input logic [15:0] d, input int n);
    gap(2);
    `CHK("op_kind", k, last_op.kind)
    `CHK("op_addr", a, last_op.addr)
    `CHK("op_data", d, last_op.data)
    `CHK("op_count", n, op_cnt - base)
    base = op_cnt;
  endtask : chk_op
  task automatic wait_ready();
    int i;
    i = 0;
    gap(3);
    while (st[7] !== 1'h1 && i < 600) begin
      gap(1);
      i++;
    end
    `CHK("ready", 1'h1, st[7])
  endtask : wait_ready
  task automatic chk_rst();
    `CHK("rstate", FCMD_RS_ARRAY, rs)
    `CHK("rcfg", `FCMD_RCFG_RST, cfg)
    `CHK("burst", 1'h0, burst)
    `CHK("wait", 1'h1, wt)
    `CHK("status", 8'h80, st)
    $display("test reset done");
  endtask : chk_rst
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done
  initial begin
    #(4 * 20000);
    fail_count++;
    test_done();
  end
  initial begin
    repeat (12) @(posedge clk_i);
    srst_i <= 1'h0;
    #1;
    chk_rst();
    wr(TA, 16'h00FF);
    for (int j = 0; j < 16; j++) rd(TA + 27'(j), aw(TA + 27'(j)));
    rd(TA + 27'h000_0040, aw(TA + 27'h000_0040));
    cyc(1'h0, 1'h0, TA + 27'h000_0005, 16'h0000);
    rd(TA + 27'h000_0009, aw(TA + 27'h000_0005));
    avs_n <= 1'h1;
    gap(2);
    @(posedge clk_i);
    avs_n <= 1'h0;
    wr(TA, 16'h0090);
    rd(TA + 27'h000_0001, ~(TA[15:0] + 16'h0001));
    wr(TA, 16'h0098);
    rd(TA + 27'h000_0002, (TA[15:0] + 16'h0002) ^ 16'h0F0F);
    gap(3);
    `CHK("rstate", FCMD_RS_QUERY, rs)
    `CHK("reads", 0, eq.size())
    $display("test reads done");
    for (int i = 0; i < 7; i++) begin
      wr(TA, c1[i]);
      wr(TA, c2[i]);
      chk_op(kk[i], TA, c2[i], 1);
      wait_ready();
    end
    wr(TA, 16'h0070);
    rd(TA + 27'h000_0003, 16'h0080);
    for (int i = 0; i < 5; i++) begin
      wr(TA, s1[i]);
      wr(TA, s2[i]);
      gap(3);
      `CHK("seq_error", 8'hB0, st)
      `CHK("err_state", FCMD_RS_STATUS, rs)
      wr(TA, 16'h0050);
      gap(3);
      `CHK("cleared", 8'h80, st)
    end
    $display("test two-cycle done");
    wr(TA, 16'h00E8);
    wr(TA, `FCMD_BUF_MAX_M1);
    // Low data byte stays clear of the command codes the checker watches
    for (int j = 0; j < 512; j++) wr(TA + 27'(j), 16'(j) << 7);
    wr(TA, 16'h00D0);
    chk_op(FCMD_OP_BUF_PROG, TA, `FCMD_BUF_MAX_M1, 513);
    wait_ready();
    wr(TA, 16'h00EB);
    wr(TA, 16'h0011);
    wr(TA, 16'h0000);
    wr(TA, 16'hBEEF);
    wr(TA, 16'h00D0);
    chk_op(FCMD_OP_EXT_GO, TA, 16'h0011, 2);
    wait_ready();
    $display("test buffers done");
    dly <= 8'hC8;
    wr(TA, 16'h0020);
    wr(TA, 16'h00D0);
    chk_op(FCMD_OP_ERASE, TA, 16'h00D0, 1);
    wr(TA, 16'h00B0);
    chk_op(FCMD_OP_SUSPEND, TA, 16'h00B0, 1);
    gap(1);
    `CHK("suspended", 8'hC0, st)
    wr(TA, 16'h00D0);
    chk_op(FCMD_OP_RESUME, TA, 16'h00D0, 1);
    wr(TA, 16'h0040);
    gap(3);
    `CHK("busy_refuse", base, op_cnt)
    `CHK("busy", 1'h0, st[7])
    wait_ready();
    dly <= 8'h14;
    $display("test suspend done");
    wr({10'h000, 16'h0400, 1'h0}, 16'h0060);
    wr({10'h000, 16'h0400, 1'h0}, 16'h0003);
    gap(3);
    `CHK("rcfg", 16'h0400, cfg)
    `CHK("wait", 1'h0, wt)
    `CHK("burst", 1'h1, burst)
    `CHK("rstate", FCMD_RS_ARRAY, rs)
    rd(TA + 27'h000_0007, aw(TA + 27'h000_0007));
    wr({10'h000, `FCMD_RCFG_RST, 1'h0}, 16'h0060);
    wr({10'h000, `FCMD_RCFG_RST, 1'h0}, 16'h0003);
    gap(3);
    `CHK("wait", 1'h1, wt)
    $display("test config done");
    wr(TA, 16'h0080);
    wr(TA, 16'h00D0);
    chk_op(FCMD_OP_BULK_START, TA, 16'h00D0, 1);
    wr(TA + 27'h000_0002, 16'h1111);
    chk_op(FCMD_OP_BULK_WORD, TA + 27'h000_0002, 16'h1111, 1);
    wr(TA + 27'h001_0000, 16'h2222);
    gap(3);
    `CHK("bulk_exit", base, op_cnt)
    @(posedge clk_i);
    srst_i <= 1'h1;
    repeat (3) @(posedge clk_i);
    srst_i <= 1'h0;
    gap(1);
    chk_rst();
    test_done();
  end
endmodule : tb_top
`default_nettype wire
